/* File: hdl/sdp_pkg.sv */
package sdp_pkg;
    localparam int CLK_PS = 20000;
    localparam int DW = 16;
    localparam int AW = 13;
    localparam int BW = 2;
    localparam int NBANK = 4;

    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LMR = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_INH = 4'hF;

    function automatic int cyc_up(input int ps);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int PWRUP_NS = 100000;
    localparam int PWRUP_CYC = cyc_up(PWRUP_NS * 1000);
    localparam int REFRESH_INTERVAL_PS = 7810000;
    localparam int REFI_CYC = REFRESH_INTERVAL_PS / CLK_PS;
    localparam int REFRESH_CYCLE_TIME_PS = 66000;
    localparam int RFC_CYC = cyc_up(REFRESH_CYCLE_TIME_PS);
    localparam int SELF_REFRESH_EXIT_TIME_PS = 75000;
    localparam int XSR_MIN_CLK = 2;
    localparam int XSR_RAW = cyc_up(SELF_REFRESH_EXIT_TIME_PS);
    localparam int XSR_CYC = (XSR_RAW < XSR_MIN_CLK) ? XSR_MIN_CLK : XSR_RAW;
    localparam int ROW_ACTIVE_TIME_PS = 44000;
    localparam int RAS_CYC = cyc_up(ROW_ACTIVE_TIME_PS);
    localparam int ROW_TO_COL_PS = 20000;
    localparam int RCD_CYC = cyc_up(ROW_TO_COL_PS);
    localparam int PRECHARGE_PERIOD_PS = 20000;
    localparam int RP_CYC = cyc_up(PRECHARGE_PERIOD_PS);
    localparam int WRITE_RECOVERY_TIME_PS = 15000;
    localparam int WR_CYC = cyc_up(WRITE_RECOVERY_TIME_PS);
    localparam int WRITE_RECOVERY_AP_PS = 7500;
    localparam int WR_AP_CYC = 1 + cyc_up(WRITE_RECOVERY_AP_PS);
    localparam int MODE_LOAD_DELAY_DEV = 2;
    localparam int MODE_LOAD_DELAY_CYC = 3;
    localparam int ROWS = 8192;
    localparam int REFRESH_WINDOW_MS = 64;
    localparam int SR_LONG_MS = 64;
    localparam int SR_LONG_CYC = SR_LONG_MS * (1000000000 / CLK_PS);
    localparam int WAKE_REFS = 2;

    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam int AP_BIT = 10;
    localparam int READ_LATENCY = 2;
    localparam logic [12:0] MODE_VALUE = 13'h0020;
    localparam logic [12:0] COL_KEEP = 13'h01FF;
    localparam int MAX_CL = 3;
endpackage

/* File: hdl/sdp_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface sdp_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [15:0] dq_ctl;
    logic dq_ctl_oe;
    logic [15:0] dq_dev;
    logic dq_dev_oe;
    logic [15:0] dq;
    // shared data wire; the device wins while its output is enabled
    assign dq = dq_dev_oe ? dq_dev : dq_ctl;
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                 output dq_ctl, dq_ctl_oe, input dq);
    modport dev (input cke, cs_n, ras_n, cas_n, we_n, ba, addr,
                 output dq_dev, dq_dev_oe, input dq);
endinterface
`default_nettype wire

/* File: hdl/sdp_device.sv */
`timescale 1ns/100ps
`default_nettype none
module sdp_device (
    input wire logic clock, // system clock
    input wire logic rst, // async reset, high
    sdp_if.dev bus, // memory pins
    output logic in_self_refresh, // self refresh active
    output logic [12:0] refresh_row, // next row to refresh
    output logic [3:0] bank_open // row open per bank
);
    import sdp_pkg::*;
    logic [3:0] cmd;
    logic [12:0] col;
    logic cke_q;
    logic live;
    logic [2:0] bl_code;
    logic [2:0] cl;
    logic [3:0] beats;
    logic [1:0] b_ba;
    logic [12:0] b_col;
    logic b_wr;
    logic b_ap;
    logic start;
    logic cont;
    logic beat;
    logic last;
    logic cur_wr;
    logic cur_ap;
    logic [1:0] cur_ba;
    logic [12:0] cur_col;
    logic [3:0] len;
    logic [8:0] sr_tick;
    logic [15:0] mem [16];
    logic [15:0] rd_line [MAX_CL];
    logic [MAX_CL-1:0] rd_vld;

    assign cmd = bus.cs_n ? CMD_NOP : {1'b0, bus.ras_n, bus.cas_n, bus.we_n}; // R4
    assign col = bus.addr & COL_KEEP; // R17
    // low clock enable suspends command decode and bursts
    assign live = cke_q && bus.cke;
    assign len = (bl_code > 3'h3) ? 4'h8 : 4'(4'h1 << bl_code[1:0]);
    assign start = live && (cmd == CMD_RD || cmd == CMD_WR);
    assign cont = live && beats != 4'h0 && cmd != CMD_BST
        && !(cmd == CMD_PRE && (bus.addr[AP_BIT] || bus.ba == b_ba));
    assign beat = start || cont;
    assign last = start ? (len == 4'h1) : (cont && beats == 4'h1);
    assign cur_wr = start ? (cmd == CMD_WR) : b_wr;
    assign cur_ap = start ? bus.addr[AP_BIT] : b_ap;
    assign cur_ba = start ? bus.ba : b_ba;
    assign cur_col = start ? col : b_col;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cke_q <= 1'b0;
        end else begin
            cke_q <= bus.cke;
        end
    end

    // self refresh keeps its own row timer running with no upper limit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            in_self_refresh <= 1'b0;
            sr_tick <= 9'h000;
            refresh_row <= 13'h0000;
        end else if (in_self_refresh) begin
            in_self_refresh <= !bus.cke;
            if (sr_tick == 9'(REFI_CYC - 1)) begin // R7
                sr_tick <= 9'h000;
                refresh_row <= refresh_row + 13'h0001;
            end else begin
                sr_tick <= sr_tick + 9'h001;
            end
        end else if (cke_q && !bus.cke && cmd == CMD_REF) begin
            in_self_refresh <= 1'b1;
            sr_tick <= 9'h000;
        end else if (live && cmd == CMD_REF) begin
            refresh_row <= refresh_row + 13'h0001;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bl_code <= 3'h0;
            cl <= 3'h2;
        end else if (live && cmd == CMD_LMR) begin
            bl_code <= bus.addr[MODE_BL_LSB +: 3];
            cl <= bus.addr[MODE_CL_LSB +: 3];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            beats <= 4'h0;
            b_ba <= 2'h0;
            b_col <= 13'h0000;
            b_wr <= 1'b0;
            b_ap <= 1'b0;
        end else if (start) begin
            beats <= len - 4'h1;
            b_ba <= bus.ba;
            b_col <= (col + 13'h0001) & COL_KEEP; // R17
            b_wr <= cmd == CMD_WR;
            b_ap <= bus.addr[AP_BIT];
        end else if (cont) begin
            beats <= beats - 4'h1;
            b_col <= (b_col + 13'h0001) & COL_KEEP;
        end else if (live && beats != 4'h0) begin
            beats <= 4'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (beat && cur_wr) begin
            mem[{cur_ba, cur_col[1:0]}] <= bus.dq;
        end
    end

    // read pipe; a precharge empties it so the outputs float from the next cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_vld <= '0;
        end else if (live && cmd == CMD_PRE) begin
            rd_vld <= '0; // R5
        end else if (live) begin
            rd_vld <= {rd_vld[MAX_CL-2:0], beat && !cur_wr};
        end
    end

    always_ff @(posedge clock) begin
        if (live) begin
            rd_line[0] <= mem[{cur_ba, cur_col[1:0]}];
            for (int i = 1; i < MAX_CL; i++) begin
                rd_line[i] <= rd_line[i-1];
            end
        end
    end

    assign bus.dq_dev = rd_line[(cl == 3'h3) ? 2 : ((cl == 3'h2) ? 1 : 0)];
    assign bus.dq_dev_oe = rd_vld[(cl == 3'h3) ? 2 : ((cl == 3'h2) ? 1 : 0)];

    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        logic [3:0] apc;
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                bank_open[b] <= 1'b0;
                apc <= 4'h0;
            end else if (live && cmd == CMD_ACT && bus.ba == 2'(b)) begin
                bank_open[b] <= 1'b1;
                apc <= 4'h0;
            end else if (live && cmd == CMD_PRE
                         && (bus.addr[AP_BIT] || bus.ba == 2'(b))) begin
                bank_open[b] <= 1'b0;
                apc <= 4'h0;
            end else if (last && cur_ap && cur_ba == 2'(b)) begin
                apc <= 4'(WR_AP_CYC); // R13
            end else if (apc == 4'h1) begin
                apc <= 4'h0;
                bank_open[b] <= 1'b0; // R13
            end else if (apc != 4'h0) begin
                apc <= apc - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/sdp_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// (R1) wait power-up pause, then two refreshes
// (R2) repeat two refreshes when window overrun
// (R3) mode load may precede the two refreshes
// (R4) chip select high means no operation
// (R5) outputs float after init precharge command
// (R6) only no-operation during refresh cycle time
// (R7) self refresh retains data without limit
// (R8) self-refresh exit wait, two clocks minimum
// (R9) clock toggles during self-refresh exit
// (R10) refresh all rows before self refresh again; the code skips this after a self refresh stay longer than SR_LONG_CYCLES
// (R11) constant clock during accesses; gate enable
// (R12) write recovery before manual precharge
// (R13) auto precharge write recovery plus one clock
// (R14) row active time before any precharge
// (R15) interleaved writes: recovery before precharge
// (R16) keep refreshing during power-down
// (R17) ignore unused upper column address bits
// (R18) three clocks after mode load
// (R19) device needs two clocks after mode load
// (R20) all rows refreshed every refresh window
// (R21) counters gate each command on minimums
module sdp_ctrl #(
    parameter int PWRUP_CYCLES = sdp_pkg::PWRUP_CYC,
    parameter int SR_LONG_CYCLES = sdp_pkg::SR_LONG_CYC
) (
    input wire logic clock, // system clock
    input wire logic rst, // async reset, high
    sdp_if.ctl bus, // memory pins
    input wire logic req, // access request
    input wire logic req_we, // 1 write, 0 read
    input wire logic req_ap, // use auto precharge
    input wire logic [1:0] req_ba, // bank
    input wire logic [12:0] req_row, // row
    input wire logic [8:0] req_col, // column
    input wire logic [15:0] req_wdata, // write word
    output logic req_ready, // request taken when high
    output logic [15:0] rd_data, // read word
    output logic rd_valid, // read word pulse
    input wire logic sr_req, // hold high for self refresh
    output logic sr_active, // in self refresh
    output logic init_done // initialisation finished
);
    import sdp_pkg::*;
    typedef enum logic [9:0] {
        S_PWR = 10'h001,
        S_REF = 10'h002,
        S_MRS = 10'h004,
        S_IDLE = 10'h008,
        S_RW = 10'h010,
        S_PRE = 10'h020,
        S_SR = 10'h040,
        S_SRX = 10'h080,
        S_SRE = 10'h100,
        S_ACT = 10'h200
    } sdp_state_t;
    sdp_state_t state;
    logic [15:0] wait_cnt;
    logic [3:0] ras_cnt;
    logic [1:0] refs_left;
    logic [8:0] refi_cnt;
    logic ref_due;
    logic ref_overdue;
    logic ref_take;
    logic [13:0] rows_done;
    logic [21:0] sr_cnt;
    logic sr_long;
    logic sr_ok;
    logic [3:0] cmd;
    logic l_we;
    logic l_ap;
    logic [8:0] l_col;
    logic [15:0] l_wdata;
    logic [MAX_CL-1:0] rd_pipe;

    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd;
    assign sr_active = state == S_SR;
    assign sr_ok = rows_done == 14'(ROWS) || sr_long; // R10
    assign ref_take = state == S_IDLE && wait_cnt == 16'h0000 && ref_due;
    assign req_ready = state == S_IDLE && wait_cnt == 16'h0000
        && !ref_due && !(sr_req && sr_ok);

    // one row per interval keeps the whole array inside the window;
    // a tick that finds the previous one still pending is an overrun
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            refi_cnt <= 9'h000;
            ref_due <= 1'b0;
            ref_overdue <= 1'b0;
        end else if (!init_done || state == S_SR || state == S_SRX) begin
            refi_cnt <= 9'h000;
            ref_due <= 1'b0;
            ref_overdue <= 1'b0;
        end else if (refi_cnt == 9'(REFI_CYC - 1)) begin // R20 R16
            refi_cnt <= 9'h000;
            ref_due <= 1'b1;
            ref_overdue <= ref_due; // R2
        end else begin
            refi_cnt <= refi_cnt + 9'h001;
            if (ref_take) begin
                ref_due <= 1'b0;
                ref_overdue <= 1'b0;
            end
        end
    end

    // rows refreshed since the last self refresh exit
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rows_done <= 14'(ROWS);
            sr_cnt <= 22'h000000;
            sr_long <= 1'b0;
        end else if (state == S_SRE) begin
            sr_cnt <= 22'h000000;
            sr_long <= 1'b0;
        end else if (state == S_SR) begin
            rows_done <= 14'h0000; // R10
            if (sr_cnt >= 22'(SR_LONG_CYCLES)) begin
                sr_long <= 1'b1;
            end else begin
                sr_cnt <= sr_cnt + 22'h000001;
            end
        end else if (cmd == CMD_REF && bus.cke && rows_done != 14'(ROWS)) begin
            rows_done <= rows_done + 14'h0001;
        end
    end

    // row active counter; precharge may not come before it runs out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ras_cnt <= 4'h0;
        end else if (cmd == CMD_ACT) begin
            ras_cnt <= 4'(RAS_CYC - 1); // R21
        end else if (ras_cnt != 4'h0) begin
            ras_cnt <= ras_cnt - 4'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_pipe <= '0;
            rd_valid <= 1'b0;
            rd_data <= 16'h0000;
        end else begin
            rd_pipe <= {rd_pipe[MAX_CL-2:0], cmd == CMD_RD};
            rd_valid <= rd_pipe[READ_LATENCY-1];
            if (rd_pipe[READ_LATENCY-1]) begin
                rd_data <= bus.dq;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= S_PWR;
            wait_cnt <= 16'(PWRUP_CYCLES - 1); // R1
            refs_left <= 2'h0;
            init_done <= 1'b0;
            cmd <= CMD_INH;
            bus.cke <= 1'b1;
            bus.ba <= 2'h0;
            bus.addr <= 13'h0000;
            bus.dq_ctl <= 16'h0000;
            bus.dq_ctl_oe <= 1'b0;
            l_we <= 1'b0;
            l_ap <= 1'b0;
            l_col <= 9'h000;
            l_wdata <= 16'h0000;
        end else begin
            cmd <= CMD_NOP; // R6
            bus.dq_ctl_oe <= 1'b0;
            if (wait_cnt != 16'h0000) begin
                wait_cnt <= wait_cnt - 16'h0001;
            end else begin
                unique case (state)
                    S_PWR: begin
                        cmd <= CMD_PRE;
                        bus.addr <= 13'(1 << AP_BIT);
                        wait_cnt <= 16'(RP_CYC - 1);
                        refs_left <= 2'(WAKE_REFS); // R1
                        state <= S_REF;
                    end
                    S_REF: begin
                        if (refs_left != 2'h0) begin
                            cmd <= CMD_REF;
                            refs_left <= refs_left - 2'h1;
                            wait_cnt <= 16'(RFC_CYC - 1); // R6
                        end else begin
                            // mode load placed after the refreshes
                            state <= init_done ? S_IDLE : S_MRS; // R3
                        end
                    end
                    S_MRS: begin
                        cmd <= CMD_LMR;
                        bus.addr <= MODE_VALUE;
                        wait_cnt <= 16'(MODE_LOAD_DELAY_CYC - 1); // R18 R19
                        init_done <= 1'b1;
                        state <= S_IDLE;
                    end
                    S_IDLE: begin
                        if (ref_due) begin
                            refs_left <= ref_overdue ? 2'(WAKE_REFS) : 2'h1; // R2
                            state <= S_REF;
                        end else if (sr_req && sr_ok) begin
                            state <= S_SRE;
                        end else if (req) begin
                            cmd <= CMD_ACT;
                            bus.ba <= req_ba;
                            bus.addr <= req_row;
                            l_we <= req_we;
                            l_ap <= req_ap;
                            l_col <= req_col;
                            l_wdata <= req_wdata;
                            wait_cnt <= 16'(RCD_CYC - 1);
                            state <= S_ACT;
                        end
                    end
                    S_ACT: begin
                        // clock enable stays high through the access
                        cmd <= l_we ? CMD_WR : CMD_RD; // R11
                        bus.addr <= {2'h0, l_ap, 1'b0, l_col};
                        bus.dq_ctl <= l_wdata;
                        bus.dq_ctl_oe <= l_we;
                        if (l_we && l_ap) begin
                            wait_cnt <= 16'(WR_AP_CYC + RP_CYC - 1); // R13
                        end else if (l_we) begin
                            wait_cnt <= 16'(WR_CYC - 1); // R12 R15
                        end else begin
                            wait_cnt <= 16'(READ_LATENCY - 1);
                        end
                        state <= S_RW;
                    end
                    S_RW: begin
                        if (l_ap) begin
                            state <= S_IDLE;
                        end else begin
                            state <= S_PRE;
                        end
                    end
                    S_PRE: begin
                        if (ras_cnt == 4'h0) begin // R14
                            cmd <= CMD_PRE;
                            bus.addr <= 13'h0000;
                            wait_cnt <= 16'(RP_CYC - 1);
                            state <= S_IDLE;
                        end
                    end
                    S_SRE: begin
                        cmd <= CMD_REF;
                        bus.cke <= 1'b0;
                        state <= S_SR;
                    end
                    S_SR: begin
                        if (!sr_req) begin
                            bus.cke <= 1'b1;
                            wait_cnt <= 16'(XSR_CYC - 1); // R8 R9
                            state <= S_SRX;
                        end
                    end
                    S_SRX: begin
                        refs_left <= 2'(WAKE_REFS); // R10
                        state <= S_REF;
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/sdp_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module sdp_chk #(
    parameter int PWRUP_CYCLES = sdp_pkg::PWRUP_CYC
) (
    input wire logic clock, // system clock
    input wire logic rst, // async reset, high
    input wire logic cke, // clock enable
    input wire logic cs_n, // chip select, low
    input wire logic ras_n, // row strobe, low
    input wire logic cas_n, // column strobe, low
    input wire logic we_n, // write enable, low
    input wire logic [12:0] addr, // address pins
    input wire logic dq_ctl_oe, // controller drives data
    input wire logic dq_dev_oe // device drives data
);
    import sdp_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [3:0] cmd;
    logic idle, act, pre, rfr, lmr, wr, rd;
    int unsigned since_rst;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign idle = cs_n || cmd == CMD_NOP;
    assign act = cmd == CMD_ACT;
    assign pre = cmd == CMD_PRE;
    assign rfr = cmd == CMD_REF;
    assign lmr = cmd == CMD_LMR;
    assign wr = cmd == CMD_WR;
    assign rd = cmd == CMD_RD;
    // saturates so the power-up window check costs one compare
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            since_rst <= 0;
        end else if (since_rst < PWRUP_CYCLES) begin
            since_rst <= since_rst + 1;
        end
    end
    sequence refresh_busy;
        idle [*3];
    endsequence
    sequence no_row_open;
        !(act || rfr) [*2];
    endsequence
    AST_PWRUP_QUIET: assert property (since_rst < PWRUP_CYCLES - 1 |-> idle)
        else $error("command during power-up pause");
    AST_RFC_QUIET: assert property (rfr && cke |=> refresh_busy)
        else $error("command inside refresh cycle time");
    AST_MODE_GAP: assert property (lmr |=> no_row_open)
        else $error("activate or refresh too soon after mode load");
    AST_ROW_ACTIVE: assert property (act |=> !pre [*2])
        else $error("precharge before row active time");
    AST_AP_RECOVERY: assert property (wr && addr[AP_BIT] |=> !act [*2])
        else $error("activate inside auto precharge recovery");
    AST_SR_EXIT: assert property ($rose(cke) |-> !act [*4])
        else $error("activate inside self refresh exit time");
    AST_PRE_FLOAT: assert property (pre |=> !dq_dev_oe)
        else $error("device drives data after precharge");
    AST_READ_LAT: assert property (rd |-> ##2 dq_dev_oe)
        else $error("selected read gave no data");
    AST_SEL_ONLY: assert property ($rose(dq_dev_oe) |-> $past(rd, 2))
        else $error("device drove data without selected read");
    AST_WR_DATA: assert property (wr |-> dq_ctl_oe && !dq_dev_oe)
        else $error("write beat not driven by controller");
endmodule
`default_nettype wire

/* File: bench/sdp_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module sdp_tb;
    import sdp_pkg::*;
    localparam int PWR = 20;
    logic clock, rst, req, req_we, req_ap, sr_req;
    logic [1:0] req_ba;
    logic [12:0] req_row, refresh_row, old_row;
    logic [8:0] req_col;
    logic [15:0] req_wdata, rd_data;
    logic req_ready, rd_valid, sr_active, init_done, in_self_refresh;
    logic [3:0] bank_open;
    int num_errors = 0;
    int samples_checked = 0;
    int i;
    int k;
    sdp_if bus();
    sdp_ctrl #(.PWRUP_CYCLES(PWR), .SR_LONG_CYCLES(50)) u_sdp_ctrl (
        .clock(clock), .rst(rst), .bus(bus.ctl), .req(req),
        .req_we(req_we), .req_ap(req_ap), .req_ba(req_ba),
        .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
        .sr_req(sr_req), .sr_active(sr_active), .init_done(init_done));
    sdp_device u_sdp_device (
        .clock(clock), .rst(rst), .bus(bus.dev),
        .in_self_refresh(in_self_refresh), .refresh_row(refresh_row),
        .bank_open(bank_open));
    sdp_chk #(.PWRUP_CYCLES(PWR)) u_sdp_chk (
        .clock(clock), .rst(rst), .cke(bus.cke), .cs_n(bus.cs_n),
        .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n),
        .addr(bus.addr), .dq_ctl_oe(bus.dq_ctl_oe),
        .dq_dev_oe(bus.dq_dev_oe));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic chk_word(input string name, input logic [15:0] exp,
                            input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_flag(input string name, input logic exp,
                            input logic got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(negedge clock);
            n++;
        end
        chk_flag("req_ready", 1'b1, req_ready);
    endtask
    // request held from a falling edge until the edge that takes it
    task automatic issue(input logic we, input logic ap, input logic [1:0] b,
                         input logic [8:0] c, input logic [15:0] d);
        req_we = we;
        req_ap = ap;
        req_ba = b;
        req_col = c;
        req_row = {4'h0, c};
        req_wdata = d;
        req = 1'b1;
        wait_ready();
        @(posedge clock);
        @(negedge clock);
        req = 1'b0;
    endtask
    task automatic read_chk(input logic ap, input logic [1:0] b,
                            input logic [8:0] c, input logic [15:0] d);
        issue(1'b0, ap, b, c, d);
        k = 0;
        while (rd_valid !== 1'b1 && k < 20) begin
            @(negedge clock);
            k++;
        end
        chk_word("read_latency", 16'(RCD_CYC + 1 + READ_LATENCY), k[15:0]);
        chk_word("read_data", d, rd_data);
    endtask
    task automatic sr_wait(input logic lvl, input int lim);
        k = 0;
        while (sr_active !== lvl && k < lim) begin
            @(negedge clock);
            k++;
        end
    endtask
    initial begin
        #(30000 * 20);
        num_errors++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        {req, req_we, req_ap, sr_req} = 4'h0;
        req_ba = 2'h0;
        req_row = 13'h0000;
        req_col = 9'h000;
        req_wdata = 16'h0000;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        repeat (PWR) @(negedge clock);
        chk_flag("init_done_early", 1'b0, init_done);
        wait_ready();
        chk_flag("init_done", 1'b1, init_done);
        // every bank, both precharge modes, upper column bits set
        for (i = 0; i < 8; i++) begin
            issue(1'b1, i[0] ^ i[2], i[1:0], 9'h1FC | i[2:1],
                  16'(16'hA5C0 + i));
            wait_ready();
            // with manual precharge, ready rises with the precharge still on the pins
            @(negedge clock);
            chk_word("bank_open", 16'h0000, {12'h000, bank_open});
        end
        for (i = 7; i >= 0; i--) begin
            read_chk(i[0], i[1:0], 9'h1FC | i[2:1], 16'(16'hA5C0 + i));
        end
        sr_req = 1'b1;
        sr_wait(1'b1, 2000);
        chk_flag("sr_active", 1'b1, sr_active);
        // device sees the entry command one edge later
        @(negedge clock);
        chk_flag("dev_self_refresh", 1'b1, in_self_refresh);
        repeat (60) @(negedge clock);
        chk_flag("sr_held", 1'b1, in_self_refresh);
        sr_req = 1'b0;
        sr_wait(1'b0, 200);
        wait_ready();
        chk_flag("dev_self_refresh", 1'b0, in_self_refresh);
        read_chk(1'b0, 2'h3, 9'h1FF, 16'hA5C7);
        read_chk(1'b1, 2'h0, 9'h1FC, 16'hA5C0);
        // long stay lets it go straight back in
        sr_req = 1'b1;
        sr_wait(1'b1, 400);
        chk_flag("sr_reentry", 1'b1, sr_active);
        repeat (10) @(negedge clock);
        sr_req = 1'b0;
        sr_wait(1'b0, 200);
        wait_ready();
        // short stay: no re-entry until all rows refreshed again
        sr_req = 1'b1;
        repeat (200) @(negedge clock);
        chk_flag("sr_refused", 1'b0, sr_active);
        sr_req = 1'b0;
        old_row = refresh_row;
        repeat (800) @(negedge clock);
        chk_flag("refresh_advance", 1'b1, refresh_row !== old_row);
        read_chk(1'b0, 2'h3, 9'h1FD, 16'hA5C3);
        final_report();
    end
endmodule
`default_nettype wire
